// ---- logic/cfgpin_device.sv ----
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module cfgpin_device #(
  parameter int MODE_W = 3,
  parameter logic [2:0] MODE_BONDED = 3'h7
) (
  input wire logic CLK, // 20 MHz
  input wire logic SYS_RST, // Power-up, sync high
  cfgpin_if.dev LINK, // Configuration pins
  input wire logic CFG_OK, // Bitstream load succeeded
  input wire logic CFG_FAIL, // Bitstream load failed
  input wire logic JTAG_LOAD, // Load came through JTAG
  input wire logic [cfgpin_pkg::REUSE_W-1:0] PIN_REUSE, // Reuse options
  output logic [2:0] CFG_STATE, // Sequencer state
  output logic [2:0] BOOT_MODE, // Latched boot mode
  output logic LOAD_ENABLE, // Engine may fetch bitstream
  output logic USER_MODE, // User working state
  output logic [cfgpin_pkg::REUSE_W-1:0] PINS_AS_GPIO, // Pins handed to user
  output logic JTAG_PINS_CFG, // JTAG pins act for config
  output logic SCAN_SEL_CFG // Select pin acts for config
);

  // Least low time of a reload request, in cycles less one
  localparam int LOW_W = 8;
  localparam logic [LOW_W-1:0] LOW_MIN = LOW_W'(cfgpin_pkg::RELOAD_PULSE_CYC - 1);

  // Settings the logic cannot serve are refused here
  if (MODE_W < 1 || MODE_W > cfgpin_pkg::MODE_W_MAX) begin : g_bad_mode_w
    $error("MODE_W out of range");
  end
  if (cfgpin_pkg::REUSE_JTAG >= cfgpin_pkg::REUSE_W) begin : g_bad_reuse_w
    $error("REUSE_W too narrow for the reuse options");
  end
  if (cfgpin_pkg::RELOAD_PULSE_CYC > (1 << LOW_W)) begin : g_bad_low_w
    $error("Reload pulse length does not fit the filter");
  end

  ////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    cfgpin_pkg::dev_state_t st;
    logic [2:0] mode;
    logic [cfgpin_pkg::REUSE_W-1:0] reuse;
    logic jtag_load;
    logic [LOW_W-1:0] low_cnt;
    logic ready_o;
    logic ready_oe;
    logic done_oe;
    logic load_en;
    logic user;
    logic [cfgpin_pkg::REUSE_W-1:0] gpio;
    logic jtag_cfg;
    logic scan_cfg;
  } dev_regs_t;

  localparam dev_regs_t RESET_VAL = '{
    st: cfgpin_pkg::ST_CFG_RESET,
    mode: 3'h0,
    reuse: '0,
    jtag_load: 1'b0,
    low_cnt: '0,
    ready_o: 1'b1,
    ready_oe: 1'b1,
    done_oe: 1'b1,
    load_en: 1'b0,
    user: 1'b0,
    gpio: '0,
    jtag_cfg: 1'b1,
    scan_cfg: 1'b0
  };

  dev_regs_t r_q;
  dev_regs_t r_d;
  logic [cfgpin_pkg::MODE_W_MAX-1:0] mode_pins;
  logic reload_hit;

  // Unbonded or unused mode pins read as ground
  for (genvar i = 0; i < cfgpin_pkg::MODE_W_MAX; i++) begin : g_mode_pin
    if (i < MODE_W && MODE_BONDED[i]) begin : g_bonded
      assign mode_pins[i] = LINK.boot_mode[i];
    end else begin : g_ground
      assign mode_pins[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  function automatic logic in_user_path(input cfgpin_pkg::dev_state_t s);
    return (s == cfgpin_pkg::ST_WAIT_DONE) || (s == cfgpin_pkg::ST_USER);
  endfunction

  // Reuse options only act once user mode is reached
  function automatic logic reuse_on(input dev_regs_t r, input int idx);
    return r.user && r.reuse[idx];
  endfunction

  always_comb begin
    r_d = r_q;

    // A low shorter than the least pulse width is a glitch
    reload_hit = !LINK.reload_request_n && (r_q.low_cnt >= LOW_MIN);
    if (LINK.reload_request_n) begin
      r_d.low_cnt = '0;
    end else if (r_q.low_cnt < LOW_MIN) begin
      r_d.low_cnt = r_q.low_cnt + LOW_W'(1);
    end

    // Sequencer walks reset, sample, wait ready, load, wait done, user
    case (r_q.st)
      cfgpin_pkg::ST_CFG_RESET: begin
        r_d.st = cfgpin_pkg::ST_SAMPLE;
      end
      cfgpin_pkg::ST_SAMPLE: begin
        r_d.mode = mode_pins;
        r_d.st = cfgpin_pkg::ST_WAIT_RDY;
      end
      cfgpin_pkg::ST_WAIT_RDY: begin
        if (LINK.ready) begin
          r_d.st = cfgpin_pkg::ST_LOAD;
        end
      end
      cfgpin_pkg::ST_LOAD: begin
        // Failure wins when both strobes come together
        if (CFG_FAIL) begin
          r_d.st = cfgpin_pkg::ST_FAILED;
        end else if (CFG_OK && LINK.ready) begin
          // Options only take hold once loading succeeds
          r_d.reuse = PIN_REUSE;
          r_d.jtag_load = JTAG_LOAD;
          r_d.st = cfgpin_pkg::ST_WAIT_DONE;
        end
      end
      cfgpin_pkg::ST_WAIT_DONE: begin
        // A JTAG load does not wait for completion
        if (r_q.jtag_load || LINK.done) begin
          r_d.st = cfgpin_pkg::ST_USER;
        end
      end
      cfgpin_pkg::ST_USER: begin
        // Left only by a reload request or power-up
        r_d.st = cfgpin_pkg::ST_USER;
      end
      cfgpin_pkg::ST_FAILED: begin
        // Readiness stays low until a reload or power-up
        r_d.st = cfgpin_pkg::ST_FAILED;
      end
      default: begin
        r_d.st = cfgpin_pkg::ST_CFG_RESET;
      end
    endcase

    // Held in reset for as long as the request stays low
    if (reload_hit) begin
      r_d.st = cfgpin_pkg::ST_CFG_RESET;
      r_d.reuse = '0;
      r_d.jtag_load = 1'b0;
    end

    r_d.user = (r_d.st == cfgpin_pkg::ST_USER);
    r_d.gpio = r_d.user ? r_d.reuse : '0;

    // Readiness pin
    r_d.ready_o = (r_d.st != cfgpin_pkg::ST_FAILED);
    r_d.ready_oe = !reuse_on(r_d, cfgpin_pkg::REUSE_READY);

    // Completion pin: released only on the path to user mode
    r_d.done_oe = !(in_user_path(r_d.st) && LINK.reload_request_n
                    && LINK.ready);
    if (reuse_on(r_d, cfgpin_pkg::REUSE_DONE)) begin
      r_d.done_oe = 1'b0;
    end

    // Engine fetches only while readiness is high
    r_d.load_en = (r_d.st == cfgpin_pkg::ST_LOAD) && LINK.ready;

    // Scan pins: only a finished load with JTAG reuse gives them away
    if (reuse_on(r_d, cfgpin_pkg::REUSE_JTAG)) begin
      r_d.scan_cfg = 1'b1;
      r_d.jtag_cfg = !LINK.scan_port_select_n;
    end else begin
      r_d.scan_cfg = 1'b0;
      r_d.jtag_cfg = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_q <= RESET_VAL;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  assign LINK.dev_ready_o = r_q.ready_o;
  assign LINK.dev_ready_oe = r_q.ready_oe;
  assign LINK.dev_done_o = 1'b0;
  assign LINK.dev_done_oe = r_q.done_oe;
  assign CFG_STATE = r_q.st;
  assign BOOT_MODE = r_q.mode;
  assign LOAD_ENABLE = r_q.load_en;
  assign USER_MODE = r_q.user;
  assign PINS_AS_GPIO = r_q.gpio;
  assign JTAG_PINS_CFG = r_q.jtag_cfg;
  assign SCAN_SEL_CFG = r_q.scan_cfg;

endmodule

// ---- pkg/cfgpin_pkg.sv ----
package cfgpin_pkg;

  localparam int MODE_W_MAX = 3;
  localparam int REUSE_W = 4;
  localparam int REUSE_RELOAD = 0;
  localparam int REUSE_READY = 1;
  localparam int REUSE_DONE = 2;
  localparam int REUSE_JTAG = 3;

  localparam int CLK_PERIOD_NS = 50;
  localparam int RELOAD_MIN_NS = 25;
  localparam int STABLE_MIN_NS = 1000000;

  // Least times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RELOAD_PULSE_CYC = min_cycles(RELOAD_MIN_NS);
  localparam int STABLE_CYC = min_cycles(STABLE_MIN_NS);

  // Device sequencer, Gray coded along the success path
  typedef enum logic [2:0] {
    ST_CFG_RESET = 3'h0,
    ST_SAMPLE    = 3'h1,
    ST_WAIT_RDY  = 3'h3,
    ST_LOAD      = 3'h2,
    ST_WAIT_DONE = 3'h6,
    ST_USER      = 3'h7,
    ST_FAILED    = 3'h5
  } dev_state_t;

  // Host register map, byte addresses
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  localparam int CTRL_RELOAD_BIT = 0;
  localparam int CTRL_HOLD_READY_BIT = 1;
  localparam int CTRL_HOLD_DONE_BIT = 2;
  localparam int CTRL_SCAN_SEL_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

  localparam int STAT_READY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RELOAD_BIT = 2;
  localparam int STAT_STABLE_BIT = 3;
  localparam int STAT_PULSE_BIT = 4;

endpackage

// ---- pkg/cfgpin_if.sv ----
`timescale 1ns/1ps
interface cfgpin_if;
  logic reload_request_n;
  logic [cfgpin_pkg::MODE_W_MAX-1:0] boot_mode;
  logic scan_port_select_n;
  logic dev_ready_o;
  logic dev_ready_oe;
  logic dev_done_o;
  logic dev_done_oe;
  logic host_ready_o;
  logic host_ready_oe;
  logic host_done_o;
  logic host_done_oe;
  logic ready;
  logic done;

  // Pulled up; any low driver wins
  assign ready = ~((dev_ready_oe & ~dev_ready_o) | (host_ready_oe & ~host_ready_o));
  assign done = ~((dev_done_oe & ~dev_done_o) | (host_done_oe & ~host_done_o));

  modport dev (
    input reload_request_n, boot_mode, scan_port_select_n, ready, done,
    output dev_ready_o, dev_ready_oe, dev_done_o, dev_done_oe
  );

  modport host (
    input ready, done,
    output reload_request_n, boot_mode, scan_port_select_n,
    output host_ready_o, host_ready_oe, host_done_o, host_done_oe
  );
endinterface

// ---- logic/cfgpin_host.sv ----
`timescale 1ns/1ps
module cfgpin_host #(
  parameter int STABLE_CYCLES = cfgpin_pkg::STABLE_CYC
) (
  input wire logic CLK, // 20 MHz
  input wire logic SYS_RST, // Sync reset, high
  input wire logic [3:0] AVS_ADDRESS, // Byte address
  input wire logic AVS_READ, // Read request
  input wire logic AVS_WRITE, // Write request
  input wire logic [31:0] AVS_WRITEDATA, // Write data
  input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes
  output logic [31:0] AVS_READDATA, // Read data
  output logic AVS_WAITREQUEST, // Stall
  cfgpin_if.host LINK // Configuration pins
);

  if (STABLE_CYCLES < 1) begin : g_bad_stable
    $error("STABLE_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [31:0] stable_cnt;
    logic stable;
    logic [7:0] pulse_cnt;
    logic reload_n;
    logic hold_ready;
    logic hold_done;
    logic scan_sel_n;
    logic [2:0] mode;
    logic [31:0] rdata;
    logic waitreq;
  } host_regs_t;

  localparam host_regs_t RESET_VAL = '{
    stable_cnt: 32'h0000_0000,
    stable: 1'b0,
    pulse_cnt: 8'h00,
    reload_n: 1'b1,
    hold_ready: 1'b0,
    hold_done: 1'b0,
    scan_sel_n: 1'b1,
    mode: 3'h0,
    rdata: 32'h0000_0000,
    waitreq: 1'b1
  };

  localparam logic [7:0] PULSE_LEN = 8'(cfgpin_pkg::RELOAD_PULSE_CYC);

  host_regs_t r_q;
  host_regs_t r_d;
  logic req;

  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    r_d = r_q;
    req = AVS_READ || AVS_WRITE;

    // Supplies counted stable before any reload is allowed
    if (!r_q.stable) begin
      r_d.stable_cnt = r_q.stable_cnt + 32'h0000_0001;
      r_d.stable = (r_d.stable_cnt >= 32'(STABLE_CYCLES));
    end

    if (r_q.pulse_cnt != 8'h00) begin
      r_d.pulse_cnt = r_q.pulse_cnt - 8'h01;
    end
    r_d.reload_n = (r_d.pulse_cnt == 8'h00);

    // One wait cycle per access, answered on the second
    r_d.waitreq = !(req && r_q.waitreq);
    if (req && r_q.waitreq) begin
      r_d.rdata = 32'h0000_0000;
      if (AVS_ADDRESS == cfgpin_pkg::CTRL_OFS) begin
        r_d.rdata[cfgpin_pkg::CTRL_HOLD_READY_BIT] = r_q.hold_ready;
        r_d.rdata[cfgpin_pkg::CTRL_HOLD_DONE_BIT] = r_q.hold_done;
        r_d.rdata[cfgpin_pkg::CTRL_SCAN_SEL_BIT] = r_q.scan_sel_n;
        r_d.rdata[cfgpin_pkg::CTRL_MODE_LSB +: 3] = r_q.mode;
      end else if (AVS_ADDRESS == cfgpin_pkg::STATUS_OFS) begin
        r_d.rdata[cfgpin_pkg::STAT_READY_BIT] = LINK.ready;
        r_d.rdata[cfgpin_pkg::STAT_DONE_BIT] = LINK.done;
        r_d.rdata[cfgpin_pkg::STAT_RELOAD_BIT] = r_q.reload_n;
        r_d.rdata[cfgpin_pkg::STAT_STABLE_BIT] = r_q.stable;
        r_d.rdata[cfgpin_pkg::STAT_PULSE_BIT] = (r_q.pulse_cnt != 8'h00);
      end
    end

    if (AVS_WRITE && !r_q.waitreq && AVS_ADDRESS == cfgpin_pkg::CTRL_OFS
        && AVS_BYTEENABLE[0]) begin
      r_d.hold_ready = AVS_WRITEDATA[cfgpin_pkg::CTRL_HOLD_READY_BIT];
      r_d.hold_done = AVS_WRITEDATA[cfgpin_pkg::CTRL_HOLD_DONE_BIT];
      r_d.scan_sel_n = AVS_WRITEDATA[cfgpin_pkg::CTRL_SCAN_SEL_BIT];
      r_d.mode = AVS_WRITEDATA[cfgpin_pkg::CTRL_MODE_LSB +: 3];
      // Pulse refused before supplies settle or while one runs
      if (AVS_WRITEDATA[cfgpin_pkg::CTRL_RELOAD_BIT] && r_q.stable
          && r_q.pulse_cnt == 8'h00) begin
        r_d.pulse_cnt = PULSE_LEN;
        r_d.reload_n = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_q <= RESET_VAL;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  assign AVS_READDATA = r_q.rdata;
  assign AVS_WAITREQUEST = r_q.waitreq;
  assign LINK.reload_request_n = r_q.reload_n;
  assign LINK.boot_mode = r_q.mode;
  assign LINK.scan_port_select_n = r_q.scan_sel_n;
  // Open drain: released pins float high, initial value one
  assign LINK.host_ready_o = 1'b0;
  assign LINK.host_ready_oe = r_q.hold_ready;
  assign LINK.host_done_o = 1'b0;
  assign LINK.host_done_oe = r_q.hold_done;

endmodule

// ---- bench/cfgpin_properties.sv ----
`timescale 1ns/1ps
module cfgpin_properties #(
  parameter int STABLE_CYCLES = 8
) (
  input wire logic CLK, // Clock
  input wire logic SYS_RST, // Reset
  input wire logic reload_request_n, // Reload pin
  input wire logic dev_ready_o, // Ready value
  input wire logic dev_ready_oe, // Ready enable
  input wire logic ready, // Ready wire
  input wire logic done // Done wire
);
  logic [31:0] cyc_q;
  logic [31:0] cyc_d;
  // Saturates so a long run never wraps
  always_comb cyc_d = (&cyc_q) ? cyc_q : cyc_q + 32'h1;
  always_ff @(posedge CLK) cyc_q <= SYS_RST ? 32'h0 : cyc_d;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////
  sequence s_fail;
    dev_ready_oe && !dev_ready_o;
  endsequence
  sequence s_pulse;
    !reload_request_n ##1 reload_request_n;
  endsequence
  property p_pulse; $fell(reload_request_n) |-> s_pulse; endproperty
  property p_stable; !reload_request_n |-> cyc_q >= STABLE_CYCLES; endproperty
  property p_pwr; $fell(SYS_RST) |-> reload_request_n; endproperty
  property p_rst; !reload_request_n |=> dev_ready_oe && dev_ready_o && !done; endproperty
  property p_fdone; s_fail |-> !done; endproperty
  property p_fstay; s_fail ##0 reload_request_n |=> s_fail; endproperty
  property p_dlow; (!reload_request_n || !ready) |=> !done; endproperty
  property p_drise; $rose(done) |-> $past(reload_request_n) && $past(ready); endproperty
  a_pulse: assert property (p_pulse) else $error("reload pulse width");
  a_stable: assert property (p_stable) else $error("reload too early");
  a_pwr: assert property (p_pwr) else $error("reload low at power");
  a_rst: assert property (p_rst) else $error("reset state pins");
  a_fdone: assert property (p_fdone) else $error("done high on failure");
  a_fstay: assert property (p_fstay) else $error("failed state left");
  a_dlow: assert property (p_dlow) else $error("done not low");
  a_drise: assert property (p_drise) else $error("done rose wrongly");
endmodule

// ---- bench/config_control_pin_sequencer_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module config_control_pin_sequencer_test;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic CFG_OK = 1'b0;
  logic CFG_FAIL = 1'b0;
  logic JTAG_LOAD = 1'b0;
  logic [3:0] PIN_REUSE = 4'h0;
  logic [2:0] CFG_STATE;
  logic [2:0] BOOT_MODE;
  logic LOAD_ENABLE;
  logic USER_MODE;
  logic [3:0] PINS_AS_GPIO;
  logic JTAG_PINS_CFG;
  logic SCAN_SEL_CFG;
  logic [31:0] rd;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  cfgpin_if lnk();
  cfgpin_host #(.STABLE_CYCLES(8)) i_cfgpin_host (.CLK(CLK), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINK(lnk));
  cfgpin_device i_cfgpin_device (.CLK(CLK), .SYS_RST(SYS_RST), .LINK(lnk),
    .CFG_OK(CFG_OK), .CFG_FAIL(CFG_FAIL), .JTAG_LOAD(JTAG_LOAD), .PIN_REUSE(PIN_REUSE),
    .CFG_STATE(CFG_STATE), .BOOT_MODE(BOOT_MODE), .LOAD_ENABLE(LOAD_ENABLE),
    .USER_MODE(USER_MODE), .PINS_AS_GPIO(PINS_AS_GPIO), .JTAG_PINS_CFG(JTAG_PINS_CFG),
    .SCAN_SEL_CFG(SCAN_SEL_CFG));
  cfgpin_properties #(.STABLE_CYCLES(8)) i_cfgpin_properties (.CLK(CLK),
    .SYS_RST(SYS_RST), .reload_request_n(lnk.reload_request_n),
    .dev_ready_o(lnk.dev_ready_o), .dev_ready_oe(lnk.dev_ready_oe),
    .ready(lnk.ready), .done(lnk.done));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end
  task results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Held until waitrequest is seen low at a rising edge; only the timeout ends a hang
  task access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge CLK);
    end
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task chk_rd(input logic [3:0] a, input logic [31:0] e);
    access(1'b0, a, 32'h0);
    `CHK("readdata", e, rd)
  endtask
  task wait_st(input logic [2:0] s);
    int n;
    n = 0;
    @(negedge CLK);
    while (CFG_STATE !== s && n < 50) begin
      @(negedge CLK);
      n++;
    end
    `CHK("state", s, CFG_STATE)
  endtask
  // Pulse falls at the taking edge; device reset lands one cycle later
  task reload(input logic [31:0] d);
    access(1'b1, cfgpin_pkg::CTRL_OFS, d);
    repeat (2) @(posedge CLK);
    wait_st(cfgpin_pkg::ST_LOAD);
  endtask
  task pulse(input logic fail, input logic [3:0] reuse, input logic jtag);
    @(posedge CLK);
    CFG_OK <= !fail;
    CFG_FAIL <= fail;
    PIN_REUSE <= reuse;
    JTAG_LOAD <= jtag;
    @(posedge CLK);
    CFG_OK <= 1'b0;
    CFG_FAIL <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    access(1'b1, cfgpin_pkg::CTRL_OFS, 32'h0000_0009);
    for (int i = 0; i < 4; i++) begin
      @(negedge CLK);
      `CHK("reload_n", 1'b1, lnk.reload_request_n)
    end
    `CHK("ready", 1'b1, lnk.ready)
    `CHK("host_done_oe", 1'b0, lnk.host_done_oe)
    chk_rd(cfgpin_pkg::CTRL_OFS, cfgpin_pkg::CTRL_RESET);
    chk_rd(4'h8, 32'h0000_0000);
    repeat (8) @(posedge CLK);
    chk_rd(cfgpin_pkg::STATUS_OFS, 32'h0000_000D);
    access(1'b1, cfgpin_pkg::CTRL_OFS, 32'h0000_005C);
    reload(32'h0000_005D);
    `CHK("mode", 3'h5, BOOT_MODE)
    `CHK("load_en", 1'b1, LOAD_ENABLE)
    pulse(1'b0, 4'hF, 1'b0);
    wait_st(cfgpin_pkg::ST_WAIT_DONE);
    repeat (3) @(negedge CLK);
    `CHK("user", 1'b0, USER_MODE)
    access(1'b1, cfgpin_pkg::CTRL_OFS, 32'h0000_0020);
    wait_st(cfgpin_pkg::ST_USER);
    `CHK("user", 1'b1, USER_MODE)
    `CHK("mode", 3'h5, BOOT_MODE)
    `CHK("gpio", 4'hF, PINS_AS_GPIO)
    `CHK("jtag", 1'b1, JTAG_PINS_CFG)
    `CHK("scan", 1'b1, SCAN_SEL_CFG)
    access(1'b1, cfgpin_pkg::CTRL_OFS, 32'h0000_0028);
    repeat (2) @(negedge CLK);
    `CHK("jtag", 1'b0, JTAG_PINS_CFG)
    reload(32'h0000_0029);
    `CHK("mode", 3'h2, BOOT_MODE)
    `CHK("gpio", 4'h0, PINS_AS_GPIO)
    `CHK("jtag", 1'b1, JTAG_PINS_CFG)
    `CHK("scan", 1'b0, SCAN_SEL_CFG)
    access(1'b1, cfgpin_pkg::CTRL_OFS, 32'h0000_002A);
    pulse(1'b0, 4'h0, 1'b0);
    repeat (2) @(negedge CLK);
    `CHK("load_en", 1'b0, LOAD_ENABLE)
    `CHK("done", 1'b0, lnk.done)
    access(1'b1, cfgpin_pkg::CTRL_OFS, 32'h0000_0028);
    pulse(1'b1, 4'h0, 1'b0);
    wait_st(cfgpin_pkg::ST_FAILED);
    chk_rd(cfgpin_pkg::STATUS_OFS, 32'h0000_000C);
    pulse(1'b0, 4'h0, 1'b0);
    repeat (2) @(negedge CLK);
    `CHK("state", cfgpin_pkg::ST_FAILED, CFG_STATE)
    reload(32'h0000_002D);
    pulse(1'b0, 4'h0, 1'b1);
    wait_st(cfgpin_pkg::ST_USER);
    `CHK("gpio", 4'h0, PINS_AS_GPIO)
    `CHK("jtag", 1'b1, JTAG_PINS_CFG)
    results();
  end
endmodule
